// ==== gpio_dir_route_pkg.sv ====
// Constants shared by the pin direction and routing block
package gpio_dir_route_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 12; // Register address width
    localparam int DATA_W = 32; // Register data width
    localparam int NPINS = 32; // Pins in the bank
    localparam int HALF = 16; // Pins per control register
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL_LO = 12'h31C; // Pins 0-15 control
    localparam logic [11:0] OFS_CTRL_HI = 12'h320; // Pins 16-31 control
    localparam logic [11:0] OFS_IN_LO = 12'h328; // Pins 0-15 input data
    localparam logic [11:0] OFS_IN_HI = 12'h32C; // Pins 16-31 input data
    localparam logic [11:0] OFS_OUT_LO = 12'h330; // Pins 0-15 output data
    localparam logic [11:0] OFS_OUT_HI = 12'h334; // Pins 16-31 output data
    localparam logic [11:0] OFS_INT_STAT = 12'h340; // Sticky event status, read only
    localparam logic [11:0] OFS_INT_CLR = 12'h344; // Event clear, write only
    localparam logic [11:0] OFS_INT_EN = 12'h348; // Event enable
    // ------------------------------------------------------------
    // Field layout: two bits per pin
    // ------------------------------------------------------------
    localparam int FIELD_W = 2; // Bits per pin
    localparam int SRC_POS = 0; // Source/destination bit
    localparam int DIR_POS = 1; // Direction bit
    localparam logic DIR_INPUT = 1'b0; // Pin is an input
    localparam logic DIR_OUTPUT = 1'b1; // Pin drives
    localparam logic SRC_DATA = 1'b0; // Input data register / output data
    localparam logic SRC_INTR = 1'b1; // General interrupt path
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_CTRL = 32'h0000_0000; // All inputs to data
    localparam logic [15:0] RST_OUT = 16'h0000; // Output data
    localparam logic [31:0] RST_INT_EN = 32'h0000_0000; // Events masked
    localparam logic [31:0] RST_PINS = 32'h0000_0000; // Pin samples
endpackage : gpio_dir_route_pkg

// ==== gpio_direction_routing.sv ====
// Direction and routing control for a bank of 32 general-purpose pins
`timescale 1ns/1ps
// Overview of operation
// - Direction bit 0 input, 1 output
// - Input, route 0: pin to input data
// - Input, route 1: pin to interrupt path
// - Output, route 0: drive from output data
// - Pins 16-31 fields in control at 320h
// - Registers exist only in port 0
// - Fields reset zero, presettable from configuration
// - Pins 0-15 fields in control at 31Ch
// - Input data reads 0 for output pins
module gpio_direction_routing (
    input wire logic ref_clk, // 100 MHz core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic is_port0, // High when this function is port 0
    input wire logic preset_we, // Preset write from configuration memory
    input wire logic preset_hi, // Preset target: 1 pins 16-31, 0 pins 0-15
    input wire logic [31:0] preset_data, // Preset control word
    input wire logic [gpio_dir_route_pkg::ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [gpio_dir_route_pkg::DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_we, // Write strobe
    input wire logic reg_re, // Read strobe
    output logic [gpio_dir_route_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [gpio_dir_route_pkg::NPINS-1:0] gpio_in, // Pin levels
    output logic [gpio_dir_route_pkg::NPINS-1:0] gpio_out, // Pin drive values
    output logic [gpio_dir_route_pkg::NPINS-1:0] gpio_oe_n, // Pin drive enables, low drives
    output logic irq // Level interrupt
);
    import gpio_dir_route_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic port0_q; // Port 0 flag
    logic [31:0] pin_dir_route_low_q; // Pins 0-15 control
    logic [31:0] pin_dir_route_high_q; // Pins 16-31 control
    logic [63:0] ctrl_all; // Both control words
    logic [NPINS-1:0] dir_vec; // Direction per pin
    logic [NPINS-1:0] src_vec; // Route per pin
    logic [15:0] out_lo_q; // Pins 0-15 output data
    logic [15:0] out_hi_q; // Pins 16-31 output data
    logic [NPINS-1:0] out_all; // Both output data halves
    logic [NPINS-1:0] in_q; // Sampled pins
    logic [NPINS-1:0] in_prev_q; // Previous sample
    logic [NPINS-1:0] in_data; // Input data as read
    logic [NPINS-1:0] route_evt; // Rising edge on a routed pin
    logic [NPINS-1:0] stat_q; // Sticky event status
    logic [NPINS-1:0] stat_d; // Next status
    logic [NPINS-1:0] en_q; // Event enables
    logic [NPINS-1:0] clr_vec; // Clear mask of this cycle
    logic wr_ok; // Accepted register write
    logic rd_ok; // Accepted register read
    logic [31:0] rd_d; // Read data next
    logic [NPINS-1:0] gpio_out_q; // Pin value flops
    logic [NPINS-1:0] oe_n_q; // Pin enable flops
    logic irq_q; // Interrupt flop
    logic [31:0] rdata_q; // Read data flop

    // ------------------------------------------------------------
    // Port identity
    // ------------------------------------------------------------
    // Port flag is cleared by reset and sampled every cycle after reset release
    // A flop here keeps a changing strap from splitting one access in two
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port0_q <= 1'b0;
        end else begin
            port0_q <= is_port0;
        end
    end

    // Access is honoured only in port 0
    assign wr_ok = reg_we && port0_q;
    assign rd_ok = reg_re && port0_q;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Preset from configuration memory takes priority over the bus
    // A bus write in the same cycle is lost, even one to the word the preset does not target
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_dir_route_low_q <= RST_CTRL;
            pin_dir_route_high_q <= RST_CTRL;
        end else if (preset_we) begin
            if (preset_hi) begin
                pin_dir_route_high_q <= preset_data;
            end else begin
                pin_dir_route_low_q <= preset_data;
            end
        end else if (wr_ok && reg_addr == OFS_CTRL_LO) begin
            pin_dir_route_low_q <= reg_wdata;
        end else if (wr_ok && reg_addr == OFS_CTRL_HI) begin
            pin_dir_route_high_q <= reg_wdata;
        end
    end

    assign ctrl_all = {pin_dir_route_high_q, pin_dir_route_low_q};

    // Per pin field extraction, two bits each
    // Pin n owns bits 2n and 2n+1 of the joined word
    for (genvar n = 0; n < NPINS; n++) begin : g_pin
        assign dir_vec[n] = ctrl_all[FIELD_W*n+DIR_POS];
        assign src_vec[n] = ctrl_all[FIELD_W*n+SRC_POS];
    end

    // ------------------------------------------------------------
    // Output data registers
    // ------------------------------------------------------------
    // Software written drive values
    // Only the low half of the bus word is kept; the rest reads zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_lo_q <= RST_OUT;
            out_hi_q <= RST_OUT;
        end else if (wr_ok && reg_addr == OFS_OUT_LO) begin
            out_lo_q <= reg_wdata[15:0];
        end else if (wr_ok && reg_addr == OFS_OUT_HI) begin
            out_hi_q <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Both output data halves as one word
    assign out_all = {out_hi_q, out_lo_q};

    // Output pins follow output data; inputs are released.
    // A route bit of 1 on an output is not meaningful and is ignored.
    // A flop on each pin keeps decode glitches off the board
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_out_q <= RST_PINS;
            oe_n_q <= ~RST_PINS;
        end else begin
            gpio_out_q <= out_all & dir_vec;
            oe_n_q <= ~dir_vec;
        end
    end

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // Pins are synchronous; one sample plus history for edges
    // A pin high at reset release looks like an edge; routing is off then
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_q <= RST_PINS;
            in_prev_q <= RST_PINS;
        end else begin
            in_q <= gpio_in;
            in_prev_q <= in_q;
        end
    end

    // Input data shows the pin for inputs, zero for outputs
    assign in_data = in_q & ~dir_vec;

    // ------------------------------------------------------------
    // Interrupt path
    // ------------------------------------------------------------
    // Only inputs routed to the interrupt path raise events
    assign route_evt = in_q & ~in_prev_q & ~dir_vec & src_vec;
    // Write one to clear; zero bits leave status alone
    assign clr_vec = (wr_ok && reg_addr == OFS_INT_CLR) ? reg_wdata : '0;
    // A new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~clr_vec) | route_evt;

    // Sticky status and enable
    // Status sets even while masked, so a later enable raises the line one edge after en_q loads
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= RST_PINS;
            en_q <= RST_INT_EN;
        end else begin
            stat_q <= stat_d;
            if (wr_ok && reg_addr == OFS_INT_EN) begin
                en_q <= reg_wdata;
            end
        end
    end

    // Level interrupt while an enabled status bit is set
    // Built from the next status so the line follows an event by one edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & en_q);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Address decode; unmapped and write-only addresses read zero
    always_comb begin
        rd_d = '0;
        if (!rd_ok) begin
            rd_d = '0;
        end else if (reg_addr == OFS_CTRL_LO) begin
            rd_d = pin_dir_route_low_q;
        end else if (reg_addr == OFS_CTRL_HI) begin
            rd_d = pin_dir_route_high_q;
        end else if (reg_addr == OFS_IN_LO) begin
            rd_d = {16'h0000, in_data[15:0]};
        end else if (reg_addr == OFS_IN_HI) begin
            rd_d = {16'h0000, in_data[31:16]};
        end else if (reg_addr == OFS_OUT_LO) begin
            rd_d = {16'h0000, out_lo_q};
        end else if (reg_addr == OFS_OUT_HI) begin
            rd_d = {16'h0000, out_hi_q};
        end else if (reg_addr == OFS_INT_STAT) begin
            rd_d = stat_q;
        end else if (reg_addr == OFS_INT_EN) begin
            rd_d = en_q;
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign gpio_out = gpio_out_q;
    assign gpio_oe_n = oe_n_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Checks run out of reset only; at the first edge $past sees reset values

    // Write to high control sets pin 16 direction next cycle
    AST_HI_LAYOUT: assert property (
        (reg_we && port0_q && !preset_we && reg_addr == OFS_CTRL_HI)
        |=> dir_vec[16] == $past(reg_wdata[1]) && src_vec[31] == $past(reg_wdata[30]))
        else $error("high control layout wrong");

    // Write to low control sets pin 15 direction and pin 0 route next cycle
    AST_LO_LAYOUT: assert property (
        (reg_we && port0_q && !preset_we && reg_addr == OFS_CTRL_LO)
        |=> dir_vec[15] == $past(reg_wdata[31]) && src_vec[0] == $past(reg_wdata[0]))
        else $error("low control layout wrong");

    // Pin 3 is not driven once it has been an input for two cycles in a row
    AST_INPUT_RELEASED: assert property (
        (!dir_vec[3])[*2] |-> gpio_oe_n[3])
        else $error("input pin driven");

    // Pin 16 output drives its output data bit
    AST_OUTPUT_DRIVE: assert property (
        $past(dir_vec[16]) |-> !gpio_oe_n[16] && gpio_out[16] == $past(out_hi_q[0]))
        else $error("output pin not driven from data");

    // Pin 0 output drives its low data bit
    AST_OUTPUT_DRIVE_LO: assert property (
        $past(dir_vec[0]) |-> !gpio_oe_n[0] && gpio_out[0] == $past(out_lo_q[0]))
        else $error("low output pin not driven from data");

    // Reading input data returns pin for inputs, zero for outputs
    AST_IN_READ: assert property (
        (reg_re && port0_q && reg_addr == OFS_IN_LO)
        |=> reg_rdata == {16'h0000, $past(in_q[15:0] & ~dir_vec[15:0])})
        else $error("input data read wrong");

    // Same for the high half
    AST_IN_READ_HI: assert property (
        (reg_re && port0_q && reg_addr == OFS_IN_HI)
        |=> reg_rdata == {16'h0000, $past(in_q[31:16] & ~dir_vec[31:16])})
        else $error("high input data read wrong");

    // Routed rising edge raises status and, if enabled, the interrupt
    AST_ROUTE_IRQ: assert property (
        (!dir_vec[1] && src_vec[1] && in_q[1] && !in_prev_q[1] && en_q[1])
        |=> stat_q[1] && irq)
        else $error("routed event lost");

    // An event in the cycle of its own clear still sets the bit
    AST_SET_WINS: assert property (
        |route_evt |=> (stat_q & $past(route_evt)) == $past(route_evt))
        else $error("event lost to clear");

    // A clear drops every named bit that saw no new event
    AST_CLEAR: assert property (
        (wr_ok && reg_addr == OFS_INT_CLR) |=> (stat_q & $past(reg_wdata) & ~$past(route_evt)) == '0)
        else $error("status not cleared");

    // Interrupt line follows enabled status while enables hold
    AST_IRQ_LEVEL: assert property (
        $stable(en_q) |-> irq == (|(stat_q & en_q)))
        else $error("interrupt level wrong");

    // Other ports read zero
    AST_NOT_PORT0: assert property (
        (reg_re && !port0_q) |=> reg_rdata == 32'h0000_0000)
        else $error("non port 0 read not zero");

    // Other ports cannot change the control or enable words
    AST_NOT_PORT0_WR: assert property (
        (reg_we && !port0_q && !preset_we)
        |=> $stable(pin_dir_route_low_q) && $stable(pin_dir_route_high_q) && $stable(en_q))
        else $error("non port 0 write landed");

    // Without a taken read the read data rests at zero
    AST_RDATA_IDLE: assert property (
        !$past(rd_ok) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not idle");

    // Preset loads the control word
    AST_PRESET: assert property (
        (preset_we && !preset_hi) |=> pin_dir_route_low_q == $past(preset_data))
        else $error("preset not applied");

    // Preset loads the high control word
    AST_PRESET_HI: assert property (
        (preset_we && preset_hi) |=> pin_dir_route_high_q == $past(preset_data))
        else $error("high preset not applied");

    // Per pin drive checks over the whole bank
    for (genvar p = 0; p < NPINS; p++) begin : g_pin_chk
        // Input pins stay released and low
        AST_PIN_RELEASE: assert property (
            !$past(dir_vec[p]) |-> gpio_oe_n[p] && !gpio_out[p])
            else $error("input pin not released");
        // Output pins drive their data bit, whatever the route bit holds
        AST_PIN_DRIVE: assert property (
            $past(dir_vec[p]) |-> !gpio_oe_n[p] && gpio_out[p] == $past(out_all[p]))
            else $error("output pin drive wrong");
    end
endmodule : gpio_direction_routing

// ==== tb_top.sv ====
// Self-checking testbench for the pin direction and routing block
`timescale 1ns/1ps
module tb_top;
    import gpio_dir_route_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0; // Core clock
    logic rst_n = 1'b0; // Reset, active low
    logic is_port0 = 1'b1; // This function is port 0
    logic preset_we = 1'b0; // Preset load strobe
    logic preset_hi = 1'b0; // Preset target half
    logic [31:0] preset_data = 32'h0000_0000; // Preset word
    logic [ADDR_W-1:0] reg_addr = '0; // Bus address
    logic [DATA_W-1:0] reg_wdata = '0; // Bus write data
    logic reg_we = 1'b0; // Write strobe
    logic reg_re = 1'b0; // Read strobe
    logic [DATA_W-1:0] reg_rdata; // Bus read data
    logic [NPINS-1:0] gpio_in = '0; // Pin levels
    logic [NPINS-1:0] gpio_out; // Pin drive values
    logic [NPINS-1:0] gpio_oe_n; // Pin drive enables
    logic irq; // Level interrupt
    int error_cnt = 0; // Mismatches seen
    int comparisons = 0; // Comparisons made

    gpio_direction_routing dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .is_port0(is_port0),
        .preset_we(preset_we), .preset_hi(preset_hi), .preset_data(preset_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .irq(irq));

    // ------------------------------------------------------------
    // Clock, 10 ns period
    // ------------------------------------------------------------
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data judged in the following cycle
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd_chk

    // Let registered outputs catch up, then sample off the edge
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : settle

    // Drive the pins at a clock edge
    task automatic pins(input logic [31:0] v);
        @(posedge ref_clk);
        gpio_in <= v;
    endtask : pins

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Values straight out of reset: every pin an input, not driven
    task automatic test_reset();
        rd_chk(OFS_CTRL_LO, RST_CTRL);
        rd_chk(OFS_CTRL_HI, RST_CTRL);
        chk(gpio_oe_n, 32'hFFFF_FFFF);
        chk({31'h0, irq}, 32'h0);
    endtask : test_reset

    // Pin 0 and pin 16 as outputs; pin 16 also carries the reserved route bit
    task automatic test_outputs();
        wr(OFS_OUT_LO, 32'h0000_0001);
        wr(OFS_OUT_HI, 32'h0000_0001);
        wr(OFS_CTRL_LO, 32'h0000_0002);
        wr(OFS_CTRL_HI, 32'h0000_0003);
        settle();
        chk(gpio_oe_n, 32'hFFFE_FFFE);
        chk(gpio_out, 32'h0001_0001);
        rd_chk(OFS_CTRL_HI, 32'h0000_0003);
    endtask : test_outputs

    // Input data shows pin levels, output pins read back 0
    task automatic test_inputs();
        pins(32'h5A5B_A5A5);
        settle();
        rd_chk(OFS_IN_LO, 32'h0000_A5A4);
        rd_chk(OFS_IN_HI, 32'h0000_5A5A);
        pins(32'h0000_0000);
    endtask : test_inputs

    // Pin 1 routed to the interrupt path: raise, clear, mask
    task automatic test_irq();
        wr(OFS_CTRL_LO, 32'h0000_0006);
        wr(OFS_INT_EN, 32'h0000_0002);
        pins(32'h0000_0002);
        settle();
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFS_INT_STAT, 32'h0000_0002);
        wr(OFS_INT_CLR, 32'h0000_0002);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr(OFS_INT_EN, 32'h0000_0000);
        pins(32'h0000_0000);
        settle();
        // Pin 2 routes to data, so its edge must not set a status bit
        pins(32'h0000_0006);
        settle();
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFS_INT_STAT, 32'h0000_0002);
        rd_chk(OFS_IN_LO, 32'h0000_0006);
        wr(OFS_INT_CLR, 32'h0000_0002);
        // Pin 1 rises so that its event meets a clear of the same bit
        pins(32'h0000_0000);
        settle();
        pins(32'h0000_0002);
        wr(OFS_INT_CLR, 32'h0000_0002);
        settle();
        rd_chk(OFS_INT_STAT, 32'h0000_0002);
        wr(OFS_INT_CLR, 32'h0000_0002);
    endtask : test_irq

    // Not port 0: bus refused, preset still loads the control words
    task automatic test_port0();
        @(posedge ref_clk);
        is_port0 <= 1'b0;
        repeat (2) @(posedge ref_clk);
        wr(OFS_CTRL_LO, 32'hFFFF_FFFF);
        rd_chk(OFS_CTRL_LO, 32'h0000_0000);
        // Refused write left pins 0 and 16 the only drivers
        chk(gpio_oe_n, 32'hFFFE_FFFE);
        @(posedge ref_clk);
        preset_we <= 1'b1;
        preset_data <= 32'h0000_0008;
        @(posedge ref_clk);
        preset_hi <= 1'b1;
        preset_data <= 32'h0000_0000;
        @(posedge ref_clk);
        preset_we <= 1'b0;
        is_port0 <= 1'b1;
        settle();
        rd_chk(OFS_CTRL_LO, 32'h0000_0008);
        rd_chk(OFS_CTRL_HI, 32'h0000_0000);
        chk(gpio_oe_n, 32'hFFFF_FFFD);
        rd_chk(12'h000, 32'h0000_0000);
        rd_chk(OFS_INT_CLR, 32'h0000_0000);
    endtask : test_port0

    // ------------------------------------------------------------
    // Verdict and run control
    // ------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        test_reset();
        test_outputs();
        test_inputs();
        test_irq();
        test_port0();
        final_report();
    end

    // Watchdog, far beyond the hundred or so cycles the scenarios need
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule : tb_top
